// *** rtl/pmw_pkg.sv ***
/*
 * Package of the always-on power mode and wake-up controller.
 * Holds register offsets, field positions, reset values and timing counts.
 * Assumes one 25 MHz reference clock.
 */
package pmw_pkg;

   localparam int unsigned ADDR_W       = 8;
   localparam int unsigned DATA_W       = 32;
   localparam int unsigned DIV_W        = 4;

   // Register byte offsets
   localparam logic [7:0]  OFS_CTRL     = 8'h00;
   localparam logic [7:0]  OFS_WAKE_CFG = 8'h04;
   localparam logic [7:0]  OFS_WAKE_TKS = 8'h08;
   localparam logic [7:0]  OFS_RTC_CTRL = 8'h0C;
   localparam logic [7:0]  OFS_RTC_TPS  = 8'h10;
   localparam logic [7:0]  OFS_RTC_SEC  = 8'h14;
   localparam logic [7:0]  OFS_STATUS   = 8'h18;
   localparam logic [7:0]  OFS_IRQ_STAT = 8'h1C;
   localparam logic [7:0]  OFS_IRQ_MASK = 8'h20;

   // CTRL fields
   localparam int unsigned CTRL_SAVE    = 0;
   localparam int unsigned CTRL_FLASH   = 1;
   localparam int unsigned CTRL_SENSE   = 2;
   localparam int unsigned CTRL_DIV_LSB = 4;

   // WAKE_CFG fields
   localparam int unsigned WK_NFC_EN    = 0;
   localparam int unsigned WK_PIN_EN    = 1;
   localparam int unsigned WK_PIN_POL   = 2;
   localparam int unsigned WK_TMR_EN    = 3;
   localparam int unsigned WK_CFG_W     = 4;

   // RTC_CTRL fields
   localparam int unsigned RTC_EN       = 0;
   localparam int unsigned RTC_SEL_INT  = 1;

   // IRQ_STAT / IRQ_MASK fields
   localparam int unsigned IRQ_NFC      = 0;
   localparam int unsigned IRQ_PIN      = 1;
   localparam int unsigned IRQ_TMR      = 2;
   localparam int unsigned IRQ_SEC      = 3;
   localparam int unsigned IRQ_W        = 4;

   // Reset values and crystal ticks per second
   localparam logic        FLASH_RST    = 1'b1;
   localparam logic        SENSE_RST    = 1'b0;
   localparam logic [31:0] TPS_RST      = 32'h0000_8000;
   localparam logic [31:0] XTAL_TPS     = 32'h0000_8000;
   localparam logic [31:0] WAKE_TKS_RST = 32'h0000_0400;

   // Timing
   localparam int unsigned CLK_PERIOD_NS   = 40;
   localparam int unsigned SETTLE_NS       = 1000;
   localparam int unsigned SETTLE_CYC      =
      (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SETTLE_W        = 8;

   typedef enum logic [2:0] {
      PMW_ST_POR,
      PMW_ST_RUN,
      PMW_ST_SLEEP,
      PMW_ST_ENTER,
      PMW_ST_SAVE,
      PMW_ST_WAKE
   } pmw_state_t;

endpackage

// *** rtl/pmw_tick_cnt.sv ***
/*
 * Tick counter with programmable period: pulses o_hit in the cycle after the tick that
 * completes a period of i_limit ticks, then restarts from zero.
 * Assumes i_tick is a one-cycle pulse synchronous to i_clk.
 */
`timescale 1ns/1ps
module pmw_tick_cnt #(
   parameter int unsigned W = 32
) (
   input  wire logic         i_clk,
   input  wire logic         i_rst_b,
   input  wire logic         i_clr,
   input  wire logic         i_tick,
   input  wire logic [W-1:0] i_limit,
   output logic              o_hit
);
   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_inc;
   logic         wrap;

   assign cnt_inc = cnt_q + {{(W-1){1'b0}}, 1'b1};
   // A limit of zero behaves as one to avoid a dead counter
   assign wrap    = i_tick && (cnt_inc >= i_limit);

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cnt_q <= '0;
         o_hit <= 1'b0;
      end else begin
         o_hit <= !i_clr && wrap;
         if (i_clr || wrap) begin
            cnt_q <= '0;
         end else if (i_tick) begin
            cnt_q <= cnt_inc;
         end
      end
   end
endmodule // pmw_tick_cnt

// *** rtl/pmw_top.sv ***
/*
 * Always-on power mode controller: operation/sleep/power-save sequencing,
 * wake-up sources, fast clock scaling and a seconds counter, with an APB
 * register slave and a level interrupt.
 * Assumes all inputs synchronous to i_ref_clk; slow oscillator ticks arrive
 * as one-cycle pulses i_xtal_tick and i_sosc_tick.
 */
// Decided for this implementation: the APB slave port and the address map.
// Contract
// - Power save turns off flash, motor driver, sensing domains and main oscillator.
// - Sensing power is software controlled, default off; standby oscillator always runs.
// - After supply appears the block enters operation mode unprompted.
// - Software requests power save; the controller sequences entry alone.
// - Enabled NFC field detection in power save wakes the device.
// - Wake pin level wakes; its active polarity is software selectable.
// - Enabled standby timer counts slow ticks from save entry, wakes at count.
// - Wait-interrupt or wait-event instruction in operation mode enters sleep.
// - Any interrupt ends sleep and resumes CPU clocking.
// - Sleep gates CPU and memory clock; peripheral clocks keep running.
// - Software sets a divider for the fast system clock.
// - Enabled real time clock counts seconds into a readable 32-bit counter.
// - Second tick comes from crystal or internal standby oscillator by selection.
// - Software loads ticks per second for the internal oscillator reference.
// - Wake timer and seconds counter run in the always-on clock domain.
// - Crystal reference assumes 32768 ticks per second.
`timescale 1ns/1ps
module pmw_top
   import pmw_pkg::*;
#(
   parameter int unsigned TMR_W = 32
) (
   input  wire logic                   i_ref_clk,
   input  wire logic                   i_rst_b,
   input  wire logic                   i_psel,
   input  wire logic                   i_penable,
   input  wire logic                   i_pwrite,
   input  wire logic [pmw_pkg::ADDR_W-1:0] i_paddr,
   input  wire logic [pmw_pkg::DATA_W-1:0] i_pwdata,
   output logic                        o_pready,
   output logic [pmw_pkg::DATA_W-1:0]  o_prdata,
   output logic                        o_pslverr,
   input  wire logic                   i_wait_interrupt_instr,
   input  wire logic                   i_wait_event_instr,
   input  wire logic                   i_irq_any,
   input  wire logic                   i_nfc_field,
   input  wire logic                   i_wake_pin,
   input  wire logic                   i_xtal_tick,
   input  wire logic                   i_sosc_tick,
   output logic                        o_core_pwr_en,
   output logic                        o_io_pwr_en,
   output logic                        o_hb_pwr_en,
   output logic                        o_flash_pwr_en,
   output logic                        o_sense_pwr_en,
   output logic                        o_main_osc_en,
   output logic                        o_sosc_en,
   output logic                        o_core_rst_b,
   output logic                        o_cpu_clk_en,
   output logic [pmw_pkg::DIV_W-1:0]   o_clk_div,
   output logic                        o_irq
);
   import pmw_pkg::*;

   pmw_state_t              state_q;
   pmw_state_t              state_d;
   logic [SETTLE_W-1:0]     settle_q;
   logic [SETTLE_W-1:0]     settle_d;
   logic                    flash_on_q;
   logic                    sense_on_q;
   logic [DIV_W-1:0]        div_q;
   logic                    save_req_q;
   logic [WK_CFG_W-1:0]     wake_cfg_q;
   logic [TMR_W-1:0]        wake_tks_q;
   logic                    rtc_en_q;
   logic                    rtc_sel_int_q;
   logic [31:0]             rtc_tps_q;
   logic [31:0]             rtc_sec_q;
   logic [IRQ_W-1:0]        irq_stat_q;
   logic [IRQ_W-1:0]        irq_mask_q;

   // Bus decode
   logic                    acc;
   logic                    wr_done;
   logic                    rd_done;
   logic                    sel_ctrl;
   logic                    sel_wcfg;
   logic                    sel_wtks;
   logic                    sel_rctl;
   logic                    sel_tps;
   logic                    sel_sec;
   logic                    sel_stat;
   logic                    sel_istat;
   logic                    sel_imask;
   logic                    mapped;
   logic [DATA_W-1:0]       rd_mux;

   assign acc       = i_psel && i_penable;
   // Completion edge is the one that samples pready high
   assign wr_done   = acc && o_pready && i_pwrite;
   assign rd_done   = acc && o_pready && !i_pwrite;
   assign sel_ctrl  = (i_paddr == OFS_CTRL);
   assign sel_wcfg  = (i_paddr == OFS_WAKE_CFG);
   assign sel_wtks  = (i_paddr == OFS_WAKE_TKS);
   assign sel_rctl  = (i_paddr == OFS_RTC_CTRL);
   assign sel_tps   = (i_paddr == OFS_RTC_TPS);
   assign sel_sec   = (i_paddr == OFS_RTC_SEC);
   assign sel_stat  = (i_paddr == OFS_STATUS);
   assign sel_istat = (i_paddr == OFS_IRQ_STAT);
   assign sel_imask = (i_paddr == OFS_IRQ_MASK);
   assign mapped    = sel_ctrl || sel_wcfg || sel_wtks || sel_rctl ||
                      sel_tps || sel_sec || sel_stat || sel_istat ||
                      sel_imask;

   always_comb begin
      rd_mux = '0;
      if (sel_ctrl) begin
         rd_mux[CTRL_FLASH]                      = flash_on_q;
         rd_mux[CTRL_SENSE]                      = sense_on_q;
         rd_mux[CTRL_DIV_LSB +: DIV_W]           = div_q;
      end else if (sel_wcfg) begin
         rd_mux[WK_CFG_W-1:0]                    = wake_cfg_q;
      end else if (sel_wtks) begin
         rd_mux[TMR_W-1:0]                       = wake_tks_q;
      end else if (sel_rctl) begin
         rd_mux[RTC_EN]                          = rtc_en_q;
         rd_mux[RTC_SEL_INT]                     = rtc_sel_int_q;
      end else if (sel_tps) begin
         rd_mux                                  = rtc_tps_q;
      end else if (sel_sec) begin
         rd_mux                                  = rtc_sec_q;
      end else if (sel_stat) begin
         rd_mux[2:0]                             = state_q;
      end else if (sel_istat) begin
         rd_mux[IRQ_W-1:0]                       = irq_stat_q;
      end else if (sel_imask) begin
         rd_mux[IRQ_W-1:0]                       = irq_mask_q;
      end
   end

   // Wake sources and timers
   logic                    in_save;
   logic                    pin_active;
   logic                    ev_nfc;
   logic                    ev_pin;
   logic                    tmr_hit;
   logic                    sec_hit;
   logic                    rtc_tick;
   logic [31:0]             rtc_limit;
   logic                    wake_hit;

   assign in_save    = (state_q == PMW_ST_SAVE);
   assign pin_active = (i_wake_pin == wake_cfg_q[WK_PIN_POL]);
   assign ev_nfc     = in_save && wake_cfg_q[WK_NFC_EN] && i_nfc_field;
   assign ev_pin     = in_save && wake_cfg_q[WK_PIN_EN] && pin_active;
   assign wake_hit   = ev_nfc || ev_pin || tmr_hit;
   assign rtc_tick   = rtc_sel_int_q ? i_sosc_tick : i_xtal_tick;
   assign rtc_limit  = rtc_sel_int_q ? rtc_tps_q : XTAL_TPS;

   // Timer restarts on every save entry, counts only in save
   pmw_tick_cnt #(
      .W       (TMR_W)
   ) u_wake_tmr (
      .i_clk   (i_ref_clk),
      .i_rst_b (i_rst_b),
      .i_clr   (!(in_save && wake_cfg_q[WK_TMR_EN])),
      .i_tick  (i_sosc_tick),
      .i_limit (wake_tks_q),
      .o_hit   (tmr_hit)
   );

   pmw_tick_cnt #(
      .W       (32)
   ) u_sec_div (
      .i_clk   (i_ref_clk),
      .i_rst_b (i_rst_b),
      .i_clr   (!rtc_en_q),
      .i_tick  (rtc_tick),
      .i_limit (rtc_limit),
      .o_hit   (sec_hit)
   );

   // Mode sequencer
   logic                    settled;
   logic                    sleep_req;

   assign settled   = (settle_q == '0);
   assign sleep_req = i_wait_interrupt_instr || i_wait_event_instr;

   always_comb begin
      state_d  = state_q;
      settle_d = settled ? settle_q : settle_q - {{(SETTLE_W-1){1'b0}}, 1'b1};
      case (state_q)
         PMW_ST_POR: begin
            if (settled) begin
               state_d = PMW_ST_RUN;
            end
         end
         PMW_ST_RUN: begin
            if (save_req_q) begin
               state_d  = PMW_ST_ENTER;
               settle_d = SETTLE_W'(SETTLE_CYC);
            end else if (sleep_req) begin
               state_d = PMW_ST_SLEEP;
            end
         end
         PMW_ST_SLEEP: begin
            if (i_irq_any) begin
               state_d = PMW_ST_RUN;
            end
         end
         PMW_ST_ENTER: begin
            // Core held in reset while its supplies are still up
            if (settled) begin
               state_d = PMW_ST_SAVE;
            end
         end
         PMW_ST_SAVE: begin
            if (wake_hit) begin
               state_d  = PMW_ST_WAKE;
               settle_d = SETTLE_W'(SETTLE_CYC);
            end
         end
         PMW_ST_WAKE: begin
            if (settled) begin
               state_d = PMW_ST_RUN;
            end
         end
         default: begin
            state_d = PMW_ST_POR;
         end
      endcase
   end

   logic                    pwr_up;
   logic                    run_like;

   assign pwr_up   = (state_d != PMW_ST_SAVE);
   assign run_like = (state_d == PMW_ST_RUN) || (state_d == PMW_ST_SLEEP);

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state_q  <= PMW_ST_POR;
         settle_q <= SETTLE_W'(SETTLE_CYC);
      end else begin
         state_q  <= state_d;
         settle_q <= settle_d;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_core_pwr_en  <= 1'b1;
         o_io_pwr_en    <= 1'b1;
         o_hb_pwr_en    <= 1'b1;
         o_main_osc_en  <= 1'b1;
         o_flash_pwr_en <= 1'b0;
         o_sense_pwr_en <= 1'b0;
         o_sosc_en      <= 1'b1;
         o_core_rst_b   <= 1'b0;
         o_cpu_clk_en   <= 1'b0;
         o_clk_div      <= '0;
      end else begin
         o_core_pwr_en  <= pwr_up;
         o_io_pwr_en    <= pwr_up;
         o_hb_pwr_en    <= pwr_up;
         o_main_osc_en  <= pwr_up;
         o_flash_pwr_en <= pwr_up && flash_on_q;
         o_sense_pwr_en <= pwr_up && sense_on_q;
         o_sosc_en      <= 1'b1;
         o_core_rst_b   <= run_like;
         o_cpu_clk_en   <= (state_d == PMW_ST_RUN);
         o_clk_div      <= div_q;
      end
   end

   // Registers
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         flash_on_q    <= FLASH_RST;
         sense_on_q    <= SENSE_RST;
         div_q         <= '0;
         save_req_q    <= 1'b0;
         wake_cfg_q    <= '0;
         wake_tks_q    <= TMR_W'(WAKE_TKS_RST);
         rtc_en_q      <= 1'b0;
         rtc_sel_int_q <= 1'b0;
         rtc_tps_q     <= TPS_RST;
      end else begin
         if (wr_done && sel_ctrl) begin
            flash_on_q <= i_pwdata[CTRL_FLASH];
            sense_on_q <= i_pwdata[CTRL_SENSE];
            div_q      <= i_pwdata[CTRL_DIV_LSB +: DIV_W];
         end
         // Request held until the sequencer takes it
         if (wr_done && sel_ctrl && i_pwdata[CTRL_SAVE]) begin
            save_req_q <= 1'b1;
         end else if (state_q == PMW_ST_ENTER) begin
            save_req_q <= 1'b0;
         end
         if (wr_done && sel_wcfg) begin
            wake_cfg_q <= i_pwdata[WK_CFG_W-1:0];
         end
         if (wr_done && sel_wtks) begin
            wake_tks_q <= i_pwdata[TMR_W-1:0];
         end
         if (wr_done && sel_rctl) begin
            rtc_en_q      <= i_pwdata[RTC_EN];
            rtc_sel_int_q <= i_pwdata[RTC_SEL_INT];
         end
         if (wr_done && sel_tps) begin
            rtc_tps_q <= i_pwdata;
         end
      end
   end

   // Seconds count; cleared when the clock is disabled
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rtc_sec_q <= '0;
      end else if (!rtc_en_q) begin
         rtc_sec_q <= '0;
      end else if (sec_hit) begin
         rtc_sec_q <= rtc_sec_q + 32'h0000_0001;
      end
   end

   // Interrupt status: new events win over read-clear
   logic [IRQ_W-1:0]        irq_set;
   logic [IRQ_W-1:0]        irq_clr;

   assign irq_set = {sec_hit, tmr_hit, ev_pin, ev_nfc};
   assign irq_clr = (rd_done && sel_istat) ? irq_stat_q : '0;

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         irq_stat_q <= '0;
         irq_mask_q <= '0;
         o_irq      <= 1'b0;
      end else begin
         irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
         if (wr_done && sel_imask) begin
            irq_mask_q <= i_pwdata[IRQ_W-1:0];
         end
         o_irq <= |(((irq_stat_q & ~irq_clr) | irq_set) & irq_mask_q);
      end
   end

   // APB answer: one wait state, ready for one cycle
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_pready  <= 1'b0;
         o_prdata  <= '0;
         o_pslverr <= 1'b0;
      end else begin
         o_pready  <= acc && !o_pready;
         o_pslverr <= acc && !o_pready && !mapped;
         if (acc && !o_pready && !i_pwrite) begin
            o_prdata <= rd_mux;
         end
      end
   end
endmodule // pmw_top

// *** verif/pmw_properties.sv ***
/* Port checker of pmw_top, bound into every instance of it.
   Assumes an APB master that holds each request until ready. */
`timescale 1ns/1ps
module pmw_properties
   import pmw_pkg::*;
#(
   parameter int unsigned TMR_W = 32
) (
   input wire logic                        i_ref_clk,
   input wire logic                        i_rst_b,
   input wire logic                        i_psel,
   input wire logic                        i_penable,
   input wire logic                        i_pwrite,
   input wire logic [pmw_pkg::ADDR_W-1:0]  i_paddr,
   input wire logic [pmw_pkg::DATA_W-1:0]  i_pwdata,
   input wire logic                        o_pready,
   input wire logic                        o_pslverr,
   input wire logic                        i_wait_interrupt_instr,
   input wire logic                        i_wait_event_instr,
   input wire logic                        i_irq_any,
   input wire logic                        o_core_pwr_en,
   input wire logic                        o_io_pwr_en,
   input wire logic                        o_hb_pwr_en,
   input wire logic                        o_flash_pwr_en,
   input wire logic                        o_sense_pwr_en,
   input wire logic                        o_main_osc_en,
   input wire logic                        o_sosc_en,
   input wire logic                        o_core_rst_b,
   input wire logic                        o_cpu_clk_en,
   input wire logic [pmw_pkg::DIV_W-1:0]   o_clk_div
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_b);
   wire logic             acc = i_psel && i_penable && o_pready;
   wire logic             wt = i_wait_interrupt_instr || i_wait_event_instr;
   wire logic [DIV_W-1:0] wdiv = i_pwdata[7:4];
   wire logic             bad = i_paddr > OFS_IRQ_MASK || i_paddr[1:0] != 2'h0;
   sequence s_setup;
      i_psel && !i_penable ##1 i_psel && i_penable;
   endsequence
   sequence s_sleep;
      o_cpu_clk_en && wt && !i_irq_any ##1 !o_cpu_clk_en;
   endsequence
   sequence s_save_req;
      acc && i_pwrite && i_paddr == OFS_CTRL && i_pwdata[0] && o_cpu_clk_en;
   endsequence
   chk_apb_one_wait: assert property (s_setup |=> o_pready)
      else $error("ready not in second access cycle");
   chk_ready_pulse: assert property (o_pready |=> !o_pready)
      else $error("ready longer than one cycle");
   chk_err_decode: assert property (acc |-> o_pslverr == bad)
      else $error("error flag does not match address map");
   chk_div_follows: assert property (
      acc && i_pwrite && i_paddr == OFS_CTRL
      |=> ##1 o_clk_div == $past(wdiv, 2))
      else $error("divider not taken from control write");
   chk_save_domains: assert property (!o_main_osc_en |->
      !o_flash_pwr_en && !o_sense_pwr_en && !o_hb_pwr_en && !o_core_rst_b)
      else $error("domain left on with oscillator off");
   chk_sosc_runs: assert property (o_sosc_en)
      else $error("standby oscillator stopped");
   chk_sleep_gate: assert property (o_cpu_clk_en && wt && !i_irq_any
      |=> !o_cpu_clk_en && o_main_osc_en)
      else $error("wait instruction did not gate core clock");
   chk_sleep_wake: assert property (s_sleep ##0 i_irq_any |=> o_cpu_clk_en)
      else $error("interrupt did not resume core clock");
   chk_save_entry: assert property (s_save_req
      |-> ##[1:3] !o_core_rst_b ##[20:30] !o_main_osc_en)
      else $error("save request not carried out");
   chk_wake_order: assert property ($rose(o_main_osc_en) |->
      (o_core_pwr_en && o_io_pwr_en && o_hb_pwr_en && !o_core_rst_b)[*8]
      ##[10:30] (o_core_rst_b && o_cpu_clk_en))
      else $error("core released before power restored");
   chk_por_run: assert property ($rose(i_rst_b) |-> ##1
      (o_flash_pwr_en && !o_sense_pwr_en && !o_core_rst_b)[*8]
      ##[10:30] (o_core_rst_b && o_cpu_clk_en))
      else $error("no start of operation after supply");
endmodule  // pmw_properties

bind pmw_top pmw_properties #(.TMR_W(TMR_W)) u_chk (.*);

// *** verif/pmw_cpu_model.sv ***
/* Stand-in for the CPU core: wait instructions and interrupts.
   Assumes the bench chooses the command and the design gives the clock. */
`timescale 1ns/1ps
module pmw_cpu_model (
   input  wire logic       i_clk,
   input  wire logic       i_rst_b,
   input  wire logic       i_clk_en,
   input  wire logic [1:0] i_cmd,
   output logic            o_wait_int,
   output logic            o_wait_evt,
   output logic            o_irq_any
);
   // Commands: 1 wait-interrupt, 2 wait-event, 3 raise interrupt
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_wait_int <= 1'h0;
         o_wait_evt <= 1'h0;
         o_irq_any  <= 1'h0;
      end else begin
         // A stopped core executes nothing
         o_wait_int <= i_clk_en && i_cmd == 2'h1;
         o_wait_evt <= i_clk_en && i_cmd == 2'h2;
         // Pending until the core runs again to service it
         o_irq_any  <= i_cmd == 2'h3 || (o_irq_any && !i_clk_en);
      end
   end
endmodule  // pmw_cpu_model

// *** verif/tb_top.sv ***
/* Bench of pmw_top: register rows, sleep, save and wake, seconds.
   Assumes pmw_cpu_model drives the core-side inputs. */
`timescale 1ns/1ps
module tb_top;
   import pmw_pkg::*;
   typedef struct {
      logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;
   } pmw_row_t;
   logic        clk = 1'h0;
   logic        rst_b = 1'h0;
   logic        psel = 1'h0;
   logic        pen = 1'h0;
   logic        pwr = 1'h0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic        nfc = 1'h0;
   logic        pin = 1'h1;
   logic        xt = 1'h0;
   logic        so = 1'h0;
   logic [1:0]  cmd = 2'h0;
   logic [31:0] prdata, rd;
   logic [3:0]  div;
   logic        rdy, serr, e, wint, wevt, irqa, cpwr, iopwr, hbpwr, flpwr;
   logic        snpwr, osc, sosc, crst, cclk, irq;
   int          errors = 0;
   int          comparisons = 0;
   logic [3:0]  wcfg [4] = '{4'h1, 4'h2, 4'h6, 4'h8};
   logic [3:0]  wst [4] = '{4'h1, 4'h2, 4'h2, 4'h4};
   logic [3:0]  wmsk [4] = '{4'h0, 4'h2, 4'h2, 4'h4};
   pmw_row_t    rows [15] = '{
      '{1'h0, OFS_CTRL, 32'h0, 32'h2, 1'h0},
      '{1'h0, OFS_WAKE_TKS, 32'h0, 32'h400, 1'h0},
      '{1'h0, OFS_RTC_TPS, 32'h0, 32'h8000, 1'h0},
      '{1'h0, OFS_STATUS, 32'h0, 32'h1, 1'h0},
      '{1'h0, OFS_IRQ_MASK, 32'h0, 32'h0, 1'h0},
      '{1'h1, OFS_CTRL, 32'h56, 32'h0, 1'h0},
      '{1'h0, OFS_CTRL, 32'h0, 32'h56, 1'h0},
      '{1'h1, OFS_STATUS, 32'hFF, 32'h0, 1'h0},
      '{1'h0, OFS_STATUS, 32'h0, 32'h1, 1'h0},
      '{1'h1, 8'h24, 32'h1, 32'h0, 1'h1},
      '{1'h0, 8'h24, 32'h0, 32'h0, 1'h1},
      '{1'h1, OFS_WAKE_TKS, 32'h3, 32'h0, 1'h0},
      '{1'h0, OFS_WAKE_TKS, 32'h0, 32'h3, 1'h0},
      '{1'h1, OFS_RTC_TPS, 32'h4, 32'h0, 1'h0},
      '{1'h0, OFS_RTC_TPS, 32'h0, 32'h4, 1'h0}};

   always #20 clk = ~clk;

   pmw_cpu_model cpu (.i_clk(clk), .i_rst_b(rst_b), .i_clk_en(cclk),
      .i_cmd(cmd), .o_wait_int(wint), .o_wait_evt(wevt), .o_irq_any(irqa));
   pmw_top dut (.i_ref_clk(clk), .i_rst_b(rst_b), .i_psel(psel),
      .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_pready(rdy), .o_prdata(prdata), .o_pslverr(serr),
      .i_wait_interrupt_instr(wint), .i_wait_event_instr(wevt),
      .i_irq_any(irqa), .i_nfc_field(nfc), .i_wake_pin(pin),
      .i_xtal_tick(xt), .i_sosc_tick(so), .o_core_pwr_en(cpwr),
      .o_io_pwr_en(iopwr), .o_hb_pwr_en(hbpwr), .o_flash_pwr_en(flpwr),
      .o_sense_pwr_en(snpwr), .o_main_osc_en(osc), .o_sosc_en(sosc),
      .o_core_rst_b(crst), .o_cpu_clk_en(cclk), .o_clk_div(div),
      .o_irq(irq));

   task automatic report_and_stop;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] s, x);
      comparisons++;
      if (s !== x) begin
         errors++;
         $display("BAD %s expected %h seen %h", n, x, s);
      end
   endtask

   task automatic timeout;
      errors++;
      $display("BAD wait expected done seen timeout");
      report_and_stop;
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'h1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'h1;
      // Read before this edge's flop updates land
      do begin
         @(posedge clk);
         n++;
      end while (rdy !== 1'h1 && n < 20);
      if (n >= 20) timeout();
      rd = prdata;
      e = serr;
      psel <= 1'h0;
      pen <= 1'h0;
   endtask

   task automatic wait_on(ref logic s, input logic v);
      int n;
      n = 0;
      while (s !== v && n < 200) begin
         @(negedge clk);
         n++;
      end
      if (n >= 200) timeout();
   endtask

   task automatic tick(input logic x, input int k);
      repeat (k) begin
         @(posedge clk);
         xt <= x;
         so <= !x;
         @(posedge clk);
         xt <= 1'h0;
         so <= 1'h0;
      end
   endtask

   task automatic sec_is(input logic [31:0] x);
      apb(1'h0, OFS_RTC_SEC, 32'h0);
      chk("seconds", rd, x);
   endtask

   initial begin
      repeat (16) @(posedge clk);
      rst_b <= 1'h1;
      wait_on(crst, 1'h1);
      chk("pwr", {flpwr, snpwr, sosc, osc, cclk, div}, 9'h170);
      $display("test reset done");
      foreach (rows[i]) begin
         apb(rows[i].w, rows[i].a, rows[i].d);
         if (!rows[i].w) chk("read", rd, rows[i].x);
         chk("slverr", {31'h0, e}, {31'h0, rows[i].e});
      end
      chk("div_sense", {div, snpwr, flpwr}, 6'h17);
      $display("test registers done");
      for (int k = 1; k <= 2; k++) begin
         @(posedge clk);
         cmd <= k[1:0];
         @(posedge clk);
         cmd <= (k == 1) ? 2'h3 : 2'h0;
         repeat (2) @(negedge clk);
         chk("sleep", {cclk, osc}, 2'h1);
         if (k == 2) begin
            apb(1'h0, OFS_STATUS, 32'h0);
            chk("status", rd, 32'h2);
            @(posedge clk);
            cmd <= 2'h3;
         end
         @(posedge clk);
         cmd <= 2'h0;
         wait_on(cclk, 1'h1);
      end
      $display("test sleep done");
      for (int k = 0; k < 4; k++) begin
         apb(1'h1, OFS_WAKE_CFG, {28'h0, wcfg[k]});
         apb(1'h1, OFS_IRQ_MASK, {28'h0, wmsk[k]});
         apb(1'h1, OFS_CTRL, 32'h3);
         wait_on(osc, 1'h0);
         chk("off", {flpwr, snpwr, hbpwr, crst}, 4'h0);
         @(posedge clk);
         nfc <= (k == 3);
         for (int t = 1; t <= 3; t++) begin
            tick(1'h0, 1);
            repeat (6) @(negedge clk);
            chk("osc", osc, {31'h0, k == 3 && t == 3});
         end
         @(posedge clk);
         if (k == 0)
            nfc <= 1'h1;
         else
            pin <= wcfg[k][2];
         wait_on(osc, 1'h1);
         chk("restore", {cpwr, iopwr, hbpwr, crst}, 4'hE);
         wait_on(crst, 1'h1);
         @(posedge clk);
         nfc <= 1'h0;
         chk("irq", irq, {31'h0, |(wmsk[k] & wst[k])});
         apb(1'h0, OFS_IRQ_STAT, 32'h0);
         chk("cause", rd, {28'h0, wst[k]});
         apb(1'h0, OFS_IRQ_STAT, 32'h0);
         chk("cleared", {rd[30:0], irq}, 32'h0);
      end
      $display("test wake done");
      apb(1'h1, OFS_RTC_CTRL, 32'h3);
      tick(1'h0, 7);
      sec_is(32'h1);
      tick(1'h1, 4);
      tick(1'h0, 1);
      sec_is(32'h2);
      apb(1'h0, OFS_IRQ_STAT, 32'h0);
      chk("sec_irq", rd, 32'h8);
      apb(1'h1, OFS_RTC_CTRL, 32'h0);
      sec_is(32'h0);
      apb(1'h1, OFS_RTC_CTRL, 32'h1);
      tick(1'h1, 32767);
      sec_is(32'h0);
      tick(1'h1, 1);
      sec_is(32'h1);
      $display("test seconds done");
      report_and_stop();
   end
endmodule  // tb_top
